// >>> bench/dssi_chk.sv
// Purpose: Port checks of dssi_top.
// Assumes: One clock.
// Notes: Bound after the module.
module dssi_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  xfer_done,
  input wire logic [3:0]  xfer_fault,
  input wire logic [3:0]  stream_enable,
  input wire logic [3:0]  stream_abort,
  input wire logic        dma_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  property p_clr; wb_ack_o && !wb_we_i && wb_adr_i == 12'h0f4 |-> wb_dat_o == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear reads back");
  property p_rsv; wb_ack_o && !wb_we_i && wb_adr_i == 12'h0f8 |-> wb_dat_o[31:12] == 20'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("status top bits set");
  property p_rst; $fell(rst) |-> stream_enable == 4'h0 && !dma_irq; endproperty
  a_rst: assert property (p_rst) else $error("not reset");
  property p_flt; |(xfer_fault & stream_enable) |=> (stream_enable & $past(xfer_fault)) == 4'h0; endproperty
  a_flt: assert property (p_flt) else $error("enabled after fault");
  property p_dn; |(xfer_done & stream_enable) |=> (stream_enable & $past(xfer_done)) == 4'h0; endproperty
  a_dn: assert property (p_dn) else $error("enabled after done");
  property p_ab; |stream_abort |=> (stream_enable & $past(stream_abort)) == 4'h0; endproperty
  a_ab: assert property (p_ab) else $error("enabled after abort");
  property p_irq; !$stable(dma_irq) |-> wb_ack_o && wb_we_i || $past(|(xfer_done | xfer_fault)) || $past(rst); endproperty
  a_irq: assert property (p_irq) else $error("irq moved alone");
endmodule : dssi_chk
bind dssi_top dssi_chk chk (.*);

// >>> bench/dssi_eng.sv
// Purpose: Transfer engine stand-in.
// Assumes: A rise of go starts one event.
// Notes: Events reach enabled streams only.
module dssi_eng (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [3:0] stream_enable,
  input  wire logic [3:0] go,
  input  wire logic       kind,
  output logic [3:0]      xfer_done,
  output logic [3:0]      xfer_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] go_q;
  always_ff @(posedge ref_clk) begin
    go_q       <= rst ? 4'h0 : go;
    xfer_done  <= go & ~go_q & stream_enable & {4{~kind}};
    xfer_fault <= go & ~go_q & stream_enable & {4{kind}};
  end
endmodule : dssi_eng

// >>> bench/tb.sv
// Purpose: Random tests of dssi_top.
// Assumes: Seed 40.
// Notes: The engine model fires events.
`define CHK(x, y) begin cmp_count++; if ((x) !== (y)) begin fails++; $display("[ERR] %0t got %h", $time, x); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0, rst = 1, cyc = 0, we = 0, k = 0, ack, irq;
  logic [11:0] adr = 0;
  logic [31:0] dat = 0, q, rdat;
  logic [3:0]  go = 0, dn, ft, en, ab, ee = 0, ed = 0, ef = 0, r;
  logic [7:0]  m = 0, x;
  int          fails = 0, cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  dssi_top uut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
                .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .xfer_done(dn),
                .xfer_fault(ft), .stream_enable(en), .stream_abort(ab), .dma_irq(irq));
  dssi_eng eng (.ref_clk(ref_clk), .rst(rst), .stream_enable(en), .go(go), .kind(k), .xfer_done(dn),
                .xfer_fault(ft));
  function automatic logic [31:0] f_st();
    return {20'h0, ee, ef, ed};
  endfunction : f_st
  task automatic complete_run();
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge ref_clk);
    {cyc, we, adr, dat} <= {1'b1, w, a, v};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    if (n >= 20) fails++;
  endtask : bus
  always @(posedge ref_clk) begin
    if (!rst) begin
      `CHK(ab, (cyc && we && !ack && adr == 12'h0fc) ? (en & ~dat[3:0]) : 4'h0)
    end
  end
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    `CHK(q, e)
  endtask : rd
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  initial begin
    void'($urandom(40));
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    bus(1, 12'h0f8, 32'hffffffff);
    rd(12'h0f8, 32'h0);
    rd(12'h0f0, 32'h0);
    rd(12'h100, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 40; i++) begin
      {r, m, x} = 20'($urandom);
      ee = r;
      bus(1, 12'h0fc, {28'h0, r});
      bus(1, 12'h0f0, {24'h0, m});
      @(posedge ref_clk);
      {go, k} <= 5'($urandom);
      @(posedge ref_clk);
      r = go;
      go <= 0;
      repeat (2) @(posedge ref_clk);
      ef |= k ? r & ee : 4'h0;
      ed |= k ? 4'h0 : r & ee;
      ee &= ~r;
      rd(12'h0f8, f_st());
      `CHK(irq, |({ef, ed} & m))
      bus(1, 12'h0f4, {24'h0, x});
      ed &= ~x[3:0];
      ef &= ~x[7:4];
      rd(12'h0f8, f_st());
      `CHK(irq, |({ef, ed} & m))
    end
    $display("random test done");
    bus(1, 12'h0fc, 32'h1);
    @(posedge ref_clk);
    {go, k} <= 5'h02;
    bus(1, 12'h0f4, 32'h1);
    go <= 0;
    ee = 4'h0;
    ed[0] = 1'b1;
    rd(12'h0f8, f_st());
    rd(12'h0f4, 32'h0);
    $display("corner test done");
    complete_run();
  end
endmodule : tb

// >>> verilog/dssi_cfg.svh
// Purpose: Register offsets, field positions and reset values for the stream status block.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes: Definitions only.
`ifndef DSSI_CFG_SVH
`define DSSI_CFG_SVH
`define DSSI_OFF_MASK     12'h0f0
`define DSSI_OFF_CLEAR    12'h0f4
`define DSSI_OFF_STATE    12'h0f8
`define DSSI_OFF_ENABLE   12'h0fc
`define DSSI_DONE_LSB     0
`define DSSI_FAULT_LSB    4
`define DSSI_BUSY_LSB     8
`define DSSI_MASK_RST     8'h00
`define DSSI_FLAG_RST     8'h00
`define DSSI_ENABLE_RST   4'h0
`define DSSI_NSTREAM      4
`endif

// >>> verilog/dssi_pkg.sv
// Purpose: Types shared by the stream status block.
// Assumes: Four streams.
// Notes: Stream life cycle states are one-hot.
package dssi_pkg;
  typedef enum logic [2:0] {
    DSSI_IDLE  = 3'b001,
    DSSI_RUN   = 3'b010,
    DSSI_FAULT = 3'b100
  } dssi_state_t;
endpackage : dssi_pkg

// >>> verilog/dssi_stream.sv
// Purpose: Life cycle of one stream: enable, busy, completion and fault.
// Assumes: Events from the transfer engine are one-cycle pulses on ref_clk.
// Notes: Enable is held here so that hardware can drop it.
`include "dssi_cfg.svh"
module dssi_stream
  import dssi_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic sw_set_en,
  input  wire logic sw_clr_en,
  input  wire logic xfer_done,
  input  wire logic xfer_fault,
  output logic      enable_r,
  output logic      busy,
  output logic      done_evt,
  output logic      fault_evt,
  output logic      abort
);
  dssi_state_t state_r;
  dssi_state_t state_nxt;
  logic        en_nxt;

  assign busy      = (state_r == DSSI_RUN);
  assign done_evt  = busy && xfer_done && !xfer_fault;
  assign fault_evt = busy && xfer_fault;
  assign abort     = busy && sw_clr_en;

  always_comb begin
    state_nxt = state_r;
    en_nxt    = enable_r;
    case (state_r)
      DSSI_IDLE: begin
        if (sw_set_en) begin
          en_nxt    = 1'b1;
          state_nxt = DSSI_RUN;
        end
      end
      DSSI_RUN: begin
        if (xfer_fault) begin
          // Stream stays off after a bus error until software enables it again.
          en_nxt    = 1'b0;
          state_nxt = DSSI_FAULT;
        end else if (sw_clr_en || xfer_done) begin
          // Hardware drops enable at the end; a software drop resets the stream.
          en_nxt    = 1'b0;
          state_nxt = DSSI_IDLE;
        end
      end
      DSSI_FAULT: begin
        if (sw_set_en) begin
          en_nxt    = 1'b1;
          state_nxt = DSSI_RUN;
        end
      end
      default: begin
        en_nxt    = 1'b0;
        state_nxt = DSSI_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r  <= DSSI_IDLE;
      enable_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      enable_r <= en_nxt;
    end
  end
endmodule : dssi_stream

// >>> verilog/dssi_top.sv
// Purpose: Status flags, clear, mask and combined interrupt for a four-stream DMA controller.
// Assumes: Classic Wishbone slave, 32-bit data, one clock, synchronous reset.
// Notes: Ack comes one cycle after a request is seen; unmapped addresses read zero and ignore writes.
//
// Register access over Wishbone was chosen for this implementation.
`include "dssi_cfg.svh"
module dssi_top
  import dssi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  xfer_done,
  input  wire logic [3:0]  xfer_fault,
  output logic [3:0]       stream_enable,
  output logic [3:0]       stream_abort,
  output logic             dma_irq
);
  logic [7:0]  mask_r;
  logic [3:0]  done_flag_r;
  logic [3:0]  fault_flag_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [3:0]  busy;
  logic [3:0]  done_evt;
  logic [3:0]  fault_evt;
  logic [3:0]  en_q;

  wire         req       = wb_cyc_i && wb_stb_i && !ack_r;
  wire         wr        = req && wb_we_i;
  wire         lane0     = wb_sel_i[0];
  wire         hit_mask  = (wb_adr_i == `DSSI_OFF_MASK);
  wire         hit_clear = (wb_adr_i == `DSSI_OFF_CLEAR);
  wire         hit_state = (wb_adr_i == `DSSI_OFF_STATE);
  wire         hit_en    = (wb_adr_i == `DSSI_OFF_ENABLE);
  wire         wr_mask   = wr && hit_mask && lane0;
  // A clear write is only a pulse; nothing of it is stored.
  wire [7:0]   clr_bits  = (wr && hit_clear && lane0) ? wb_dat_i[7:0] : 8'h00;
  wire [3:0]   clr_fault = clr_bits[`DSSI_FAULT_LSB +: 4];
  wire [3:0]   clr_done  = clr_bits[`DSSI_DONE_LSB +: 4];
  wire         wr_en     = wr && hit_en && lane0;
  wire [3:0]   set_en    = wr_en ? (wb_dat_i[3:0] & ~en_q) : 4'h0;
  wire [3:0]   drop_en   = wr_en ? (~wb_dat_i[3:0] & en_q) : 4'h0;
  // Busy bits, flags and zeroed upper bits form the status word.
  wire [31:0]  state_word = {20'h00000, busy, fault_flag_r, done_flag_r};
  wire [31:0]  rd_mux =
    hit_mask  ? {24'h000000, mask_r} :
    hit_state ? state_word :
    hit_en    ? {28'h0000000, en_q} :
    32'h00000000;
  wire [7:0]   flags    = {fault_flag_r, done_flag_r};
  wire [7:0]   flag_rst = `DSSI_FLAG_RST;

  genvar g;
  generate
    for (g = 0; g < `DSSI_NSTREAM; g = g + 1) begin : g_stream
      dssi_stream u_stream (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .sw_set_en  (set_en[g]),
        .sw_clr_en  (drop_en[g]),
        .xfer_done  (xfer_done[g]),
        .xfer_fault (xfer_fault[g]),
        .enable_r   (en_q[g]),
        .busy       (busy[g]),
        .done_evt   (done_evt[g]),
        .fault_evt  (fault_evt[g]),
        .abort      (stream_abort[g])
      );
    end
  endgenerate

  assign stream_enable = en_q;
  assign wb_ack_o      = ack_r;
  assign wb_dat_o      = rdat_r;
  // Only unmasked flags reach the single interrupt line.
  assign dma_irq       = |(flags & mask_r);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r  <= req;
      rdat_r <= (req && !wb_we_i) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r <= `DSSI_MASK_RST;
    end else if (wr_mask) begin
      mask_r <= wb_dat_i[7:0];
    end
  end

  // Zero bits in a clear keep the flag; a same-cycle event wins over a clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_flag_r  <= flag_rst[3:0];
      fault_flag_r <= flag_rst[7:4];
    end else begin
      done_flag_r  <= (done_flag_r & ~clr_done) | done_evt;
      fault_flag_r <= (fault_flag_r & ~clr_fault) | fault_evt;
    end
  end
endmodule : dssi_top
